// file: src/idw_pkg.sv
// Package: word indices, fixed values and field positions of the identify words block
package idw_pkg;
    localparam logic [7:0]  IDW_W_CAP_LO    = 8'h39;
    localparam logic [7:0]  IDW_W_CAP_HI    = 8'h3A;
    localparam logic [7:0]  IDW_W_MULT      = 8'h3B;
    localparam logic [7:0]  IDW_W_LBA_LO    = 8'h3C;
    localparam logic [7:0]  IDW_W_LBA_HI    = 8'h3D;
    localparam logic [7:0]  IDW_W_MDMA      = 8'h3F;
    localparam logic [7:0]  IDW_W_PIO       = 8'h40;
    localparam logic [7:0]  IDW_W_MDMA_MIN  = 8'h41;
    localparam logic [7:0]  IDW_W_MDMA_REC  = 8'h42;
    localparam logic [7:0]  IDW_W_PIO_NOFC  = 8'h43;
    localparam logic [7:0]  IDW_W_PIO_FC    = 8'h44;
    localparam logic [7:0]  IDW_W_MAJOR     = 8'h50;
    localparam logic [7:0]  IDW_W_MINOR     = 8'h51;
    localparam logic [7:0]  IDW_W_SUP1      = 8'h52;
    localparam logic [7:0]  IDW_W_SUP2      = 8'h53;
    localparam logic [7:0]  IDW_W_SUP3      = 8'h54;
    localparam logic [7:0]  IDW_W_ENA1      = 8'h55;
    localparam logic [7:0]  IDW_W_ENA2      = 8'h56;
    localparam logic [7:0]  IDW_W_ENA3      = 8'h57;
    localparam logic [7:0]  IDW_W_UDMA      = 8'h58;
    localparam logic [7:0]  IDW_W_APM       = 8'h5B;
    localparam logic [7:0]  IDW_W_CTRL      = 8'hC0;
    localparam logic [7:0]  IDW_MULT_VALID  = 8'h01;
    localparam logic [7:0]  IDW_MULT_RST    = 8'h00;
    localparam logic [15:0] IDW_CYCLE_NS    = 16'h0078;
    localparam logic [15:0] IDW_MAJOR_VAL   = 16'h00FE;
    localparam logic [15:0] IDW_MINOR_VAL   = 16'h0021;
    localparam logic [15:0] IDW_SUP1_VAL    = 16'h706B;
    localparam logic [15:0] IDW_SUP2_VAL    = 16'h7408;
    localparam logic [15:0] IDW_SUP3_VAL    = 16'h4000;
    localparam logic [15:0] IDW_ENA2_VAL    = 16'h3400;
    localparam logic [15:0] IDW_APM_VAL     = 16'h0000;
    localparam logic [2:0]  IDW_MDMA_SUP    = 3'h7;
    localparam logic [1:0]  IDW_PIO_SUP     = 2'h3;
    localparam logic [6:0]  IDW_UDMA_SUP    = 7'h7F;
    localparam logic [2:0]  IDW_MDMA_RST    = 3'h1;
    localparam logic [6:0]  IDW_UDMA_RST    = 7'h00;
    localparam logic [7:0]  IDW_SF_XFER     = 8'h03;
    localparam logic [4:0]  IDW_XM_MDMA     = 5'h04;
    localparam logic [4:0]  IDW_XM_UDMA     = 5'h08;
    localparam int          IDW_EN_NOP      = 0;
    localparam int          IDW_EN_RDBUF    = 1;
    localparam int          IDW_EN_WRBUF    = 2;
    localparam int          IDW_EN_LOOK     = 3;
    localparam int          IDW_EN_WCACHE   = 4;
    localparam int          IDW_EN_PM       = 5;
    localparam logic [5:0]  IDW_EN_RST      = 6'h3F;
endpackage : idw_pkg

// file: src/idw_words_57_88.sv
// Identify data words 57 to 88 with live feature, mode and multiple state
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
// Summary of operation
// RULE1: Words 57-58 return cylinders times heads times sectors, low word first.
// RULE2: Word 59 upper byte always reads 01H.
// RULE3: Word 59 lower byte holds set-multiple count, 00H after reset.
// RULE4: Words 60-61 return LBA sector total, low word first.
// RULE5: Word 63 selection bits 10..8 hold at most one set bit (none once a UDMA mode is picked); bits 15-11 zero.
// RULE6: Word 63 bits 2..0 all set for modes 0-2; bits 7-3 zero.
// RULE7: Word 64 bits 0 and 1 set for PIO 3 and 4; 7-2 zero.
// RULE8: Translation-valid bit 1 output high, since words 64-68 are supported.
// RULE9: Word 65 reads 120 ns minimum DMA cycle.
// RULE10: Word 66 reads 120 ns recommended cycle; faster hosts may be throttled.
// RULE11: Word 67 reads 120 ns PIO cycle without IORDY.
// RULE12: Word 68 reads 120 ns PIO cycle with IORDY.
// RULE13: Word 80 sets bits 7..1 for versions one through seven.
// RULE14: Word 81 reads 0021H.
// RULE15: Word 82 reads 706BH.
// RULE16: Word 83 has bit 14, 13, 12, 10, 3 set only.
// RULE17: Power management level word 91 always reads 0000H.
// RULE18: Words 84 and 87 read 4000H.
// RULE19: Enables change only for supported features; word 85 reflects them.
// RULE20: Word 85 shows live NOP, buffers, look-ahead, cache, PM enables.
// RULE21: Word 85 bit 1 set only after set-password; bit 0 zero.
// RULE22: Word 86 reads 3400H, with bit 3 always clear.
// RULE23: Word 88 high byte flags at most one selected UDMA mode, none after reset; low byte supported modes.
// RULE24: Set-features 03H with transfer mode value changes the selected DMA mode.
// RULE25: Reserved and obsolete bits read zero, unmapped words too.
module idw_words_57_88
    import idw_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    input  wire logic [15:0] cur_cyl,
    input  wire logic [15:0] cur_heads,
    input  wire logic [15:0] cur_spt,
    input  wire logic [31:0] lba_total,
    input  wire logic        set_mult_stb,
    input  wire logic [7:0]  set_mult_cnt,
    input  wire logic        set_feat_stb,
    input  wire logic [7:0]  set_feat_sub,
    input  wire logic [7:0]  set_feat_cnt,
    input  wire logic        set_pw_stb,
    output logic [15:0] rd_data,
    output logic        xlat_pio_valid,
    output logic [5:0]  feat_en,
    output logic        sec_enabled
);
    logic [15:0] rd_data_ff;
    logic [7:0]  mult_ff;
    logic [2:0]  mdma_sel_ff;
    logic [6:0]  udma_sel_ff;
    logic [5:0]  en_ff;
    logic        sec_ff;
    logic        xlat_ff;
    logic [31:0] cap_ff;
    logic [15:0] nxt_rd_data;
    logic [5:0]  nxt_en;
    logic [2:0]  xm;
    logic        sf_xfer;

    assign rd_data        = rd_data_ff;
    assign xlat_pio_valid = xlat_ff;
    assign feat_en        = en_ff;
    assign sec_enabled    = sec_ff;
    assign xm             = set_feat_cnt[2:0];
    assign sf_xfer        = set_feat_stb && (set_feat_sub == IDW_SF_XFER);

    // Product registered to keep the multiplier off the read path
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_ff <= 32'h00000000;
        end else begin
            cap_ff <= 32'(cur_cyl * cur_heads * cur_spt); // see RULE1
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xlat_ff <= 1'b0;
        end else begin
            xlat_ff <= 1'b1; // see RULE8
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mult_ff <= IDW_MULT_RST; // see RULE3
        end else if (set_mult_stb) begin
            mult_ff <= set_mult_cnt; // see RULE3
        end
    end

    // Only modes inside the supported range are taken, one-hot by construction
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdma_sel_ff <= IDW_MDMA_RST;
            udma_sel_ff <= IDW_UDMA_RST;
        end else if (sf_xfer) begin
            if (set_feat_cnt[7:3] == IDW_XM_MDMA && xm <= 3'h2) begin
                mdma_sel_ff <= 3'(3'h1 << xm); // see RULE5, RULE24
                udma_sel_ff <= IDW_UDMA_RST;
            end else if (set_feat_cnt[7:3] == IDW_XM_UDMA && xm <= 3'h6) begin
                udma_sel_ff <= 7'(7'h01 << xm); // see RULE23, RULE24
                mdma_sel_ff <= 3'h0;
            end
        end
    end

    // Only the write-cache and look-ahead enables change; the other bits keep their reset value
    always_comb begin
        nxt_en = en_ff;
        if (set_feat_stb) begin
            case (set_feat_sub)
                8'h02:   nxt_en[IDW_EN_WCACHE] = 1'b1; // see RULE19, RULE20
                8'h82:   nxt_en[IDW_EN_WCACHE] = 1'b0;
                8'hAA:   nxt_en[IDW_EN_LOOK]   = 1'b1;
                8'h55:   nxt_en[IDW_EN_LOOK]   = 1'b0;
                default: nxt_en = en_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_ff <= IDW_EN_RST;
        end else begin
            en_ff <= nxt_en; // see RULE19
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_ff <= 1'b0;
        end else if (set_pw_stb) begin
            sec_ff <= 1'b1; // see RULE21
        end
    end

    always_comb begin
        nxt_rd_data = 16'h0000; // see RULE25
        case (addr)
            IDW_W_CAP_LO:   nxt_rd_data = cap_ff[15:0]; // see RULE1
            IDW_W_CAP_HI:   nxt_rd_data = cap_ff[31:16];
            IDW_W_MULT:     nxt_rd_data = {IDW_MULT_VALID, mult_ff}; // see RULE2
            IDW_W_LBA_LO:   nxt_rd_data = lba_total[15:0]; // see RULE4
            IDW_W_LBA_HI:   nxt_rd_data = lba_total[31:16];
            IDW_W_MDMA:     nxt_rd_data = {5'h00, mdma_sel_ff, 5'h00, IDW_MDMA_SUP}; // see RULE5, RULE6
            IDW_W_PIO:      nxt_rd_data = {14'h0000, IDW_PIO_SUP}; // see RULE7
            IDW_W_MDMA_MIN: nxt_rd_data = IDW_CYCLE_NS; // see RULE9
            IDW_W_MDMA_REC: nxt_rd_data = IDW_CYCLE_NS; // see RULE10
            IDW_W_PIO_NOFC: nxt_rd_data = IDW_CYCLE_NS; // see RULE11
            IDW_W_PIO_FC:   nxt_rd_data = IDW_CYCLE_NS; // see RULE12
            IDW_W_MAJOR:    nxt_rd_data = IDW_MAJOR_VAL; // see RULE13
            IDW_W_MINOR:    nxt_rd_data = IDW_MINOR_VAL; // see RULE14
            IDW_W_SUP1:     nxt_rd_data = IDW_SUP1_VAL; // see RULE15
            IDW_W_SUP2:     nxt_rd_data = IDW_SUP2_VAL; // see RULE16
            IDW_W_SUP3:     nxt_rd_data = IDW_SUP3_VAL; // see RULE18
            IDW_W_ENA1:     nxt_rd_data = {1'b0, en_ff[IDW_EN_NOP], en_ff[IDW_EN_RDBUF], en_ff[IDW_EN_WRBUF],
                                           5'h00, en_ff[IDW_EN_LOOK], en_ff[IDW_EN_WCACHE], 1'b0,
                                           en_ff[IDW_EN_PM], 1'b0, sec_ff, 1'b0}; // see RULE20, RULE21
            IDW_W_ENA2:     nxt_rd_data = IDW_ENA2_VAL; // see RULE22
            IDW_W_ENA3:     nxt_rd_data = IDW_SUP3_VAL; // see RULE18
            IDW_W_UDMA:     nxt_rd_data = {1'b0, udma_sel_ff, 1'b0, IDW_UDMA_SUP}; // see RULE23
            IDW_W_APM:      nxt_rd_data = IDW_APM_VAL; // see RULE17
            IDW_W_CTRL:     nxt_rd_data = {9'h000, sec_ff, en_ff};
            default:        nxt_rd_data = 16'h0000;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 16'h0000;
        end else if (rd_stb) begin
            rd_data_ff <= nxt_rd_data;
        end else begin
            rd_data_ff <= 16'h0000;
        end
    end

    // Host view of a read: strobe on one edge, the word on the next
    sequence s_rd_word(logic [7:0] w);
        rd_stb && addr == w;
    endsequence

    sequence s_pick_mdma;
        sf_xfer && set_feat_cnt[7:3] == 5'h04 && set_feat_cnt[2:0] <= 3'h2;
    endsequence

    sequence s_pick_udma;
        sf_xfer && set_feat_cnt[7:3] == 5'h08 && set_feat_cnt[2:0] <= 3'h6;
    endsequence

    sequence s_pick_bad;
        sf_xfer && !(set_feat_cnt inside {[8'h20:8'h22], [8'h40:8'h46]});
    endsequence

    sequence s_mult_then_rd;
        set_mult_stb ##1 (rd_stb && addr == IDW_W_MULT && !set_mult_stb);
    endsequence

    AST_MULT_HI: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE2
        rd_stb && addr == IDW_W_MULT |=> rd_data[15:8] == 8'h01) else $error("mult valid byte wrong");
    AST_MULT_SET: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE3
        s_mult_then_rd |=> rd_data[7:0] == $past(set_mult_cnt, 2))
        else $error("mult count not stored");
    AST_MDMA_ONEHOT: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE5
        rd_stb && addr == IDW_W_MDMA |=> $onehot0(rd_data[10:8]) && rd_data[15:11] == 5'h00 && rd_data[2:0] == 3'h7)
        else $error("mdma word malformed");
    AST_UDMA_ONEHOT: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE23
        rd_stb && addr == IDW_W_UDMA |=> $onehot0(rd_data[14:8]) && rd_data[7:0] == 8'h7F && !rd_data[15])
        else $error("udma word malformed");
    AST_CYCLE: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE9
        rd_stb && addr >= IDW_W_MDMA_MIN && addr <= IDW_W_PIO_FC |=> rd_data == 16'h0078)
        else $error("cycle time word wrong");
    AST_SUP1: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE15
        rd_stb && addr == IDW_W_SUP1 |=> rd_data == 16'h706B) else $error("supported word one wrong");
    AST_ENA2: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE22
        rd_stb && addr == IDW_W_ENA2 |=> rd_data == 16'h3400 && !rd_data[3]) else $error("enabled word two wrong");
    AST_SEC: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE21
        !sec_ff && !set_pw_stb |=> !sec_ff) else $error("security set without password");
    AST_RD_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE25
        !rd_stb |=> rd_data == 16'h0000) else $error("read data outside its cycle");
    AST_WCACHE: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE19
        set_feat_stb && set_feat_sub == 8'h82 |=> !en_ff[IDW_EN_WCACHE]) else $error("write cache not disabled");

    AST_CAP: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE1
        rst_n
        |=> cap_ff == 32'($past(cur_cyl) * $past(cur_heads) * $past(cur_spt)))
        else $error("capacity product wrong");

    AST_CAP_RD: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE1
        s_rd_word(IDW_W_CAP_HI)
        |=> rd_data == $past(cap_ff[31:16]))
        else $error("capacity high word wrong");

    AST_LBA_LO: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE4
        s_rd_word(IDW_W_LBA_LO)
        |=> rd_data == $past(lba_total[15:0]))
        else $error("lba low word wrong");

    AST_LBA_HI: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE4
        s_rd_word(IDW_W_LBA_HI)
        |=> rd_data == $past(lba_total[31:16]))
        else $error("lba high word wrong");

    AST_MULT_RST: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE3
        !$past(rst_n)
        |-> mult_ff == 8'h00 && mdma_sel_ff == 3'h1 && udma_sel_ff == 7'h00)
        else $error("state after reset wrong");

    AST_MULT_REG: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE3
        set_mult_stb
        |=> mult_ff == $past(set_mult_cnt))
        else $error("multiple count not taken");

    AST_PIO: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE7
        s_rd_word(IDW_W_PIO)
        |=> rd_data == 16'h0003)
        else $error("pio word wrong");

    AST_XLAT: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE8
        $past(rst_n)
        |-> xlat_pio_valid)
        else $error("translation valid bit low");

    AST_MDMA_REC: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE10
        s_rd_word(IDW_W_MDMA_REC)
        |=> rd_data == 16'h0078)
        else $error("recommended dma cycle wrong");

    AST_PIO_NOFC: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE11
        s_rd_word(IDW_W_PIO_NOFC)
        |=> rd_data == 16'h0078)
        else $error("pio cycle without flow control wrong");

    AST_PIO_FC: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE12
        s_rd_word(IDW_W_PIO_FC)
        |=> rd_data == 16'h0078)
        else $error("pio cycle with flow control wrong");

    AST_MAJOR: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE13
        s_rd_word(IDW_W_MAJOR)
        |=> rd_data[6:1] == 6'h3F && rd_data != 16'h0000 && rd_data != 16'hFFFF)
        else $error("major version word wrong");

    AST_MINOR: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE14
        s_rd_word(IDW_W_MINOR)
        |=> rd_data == 16'h0021)
        else $error("minor version word wrong");

    AST_SUP2: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE16
        s_rd_word(IDW_W_SUP2)
        |=> rd_data == 16'h7408)
        else $error("supported word two wrong");

    AST_APM: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE17
        s_rd_word(IDW_W_APM)
        |=> rd_data == 16'h0000)
        else $error("power level word not zero");

    AST_SUP3: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE18
        s_rd_word(IDW_W_SUP3)
        |=> rd_data == 16'h4000)
        else $error("supported word three wrong");

    AST_ENA3: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE18
        s_rd_word(IDW_W_ENA3)
        |=> rd_data == 16'h4000)
        else $error("enabled word three wrong");

    AST_ENA1: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE20
        s_rd_word(IDW_W_ENA1)
        |=> rd_data[14] == $past(en_ff[IDW_EN_NOP]) && rd_data[6] == $past(en_ff[IDW_EN_LOOK])
            && rd_data[5] == $past(en_ff[IDW_EN_WCACHE]) && rd_data[3] == $past(en_ff[IDW_EN_PM]))
        else $error("enabled word one wrong");

    AST_ENA1_SEC: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE21
        s_rd_word(IDW_W_ENA1)
        |=> rd_data[1] == $past(sec_ff) && !rd_data[0])
        else $error("security or smart bit wrong");

    AST_SEL_MDMA: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE24
        s_pick_mdma
        |=> mdma_sel_ff == 3'(3'h1 << $past(set_feat_cnt[2:0])) && udma_sel_ff == 7'h00)
        else $error("mdma mode not selected");

    AST_SEL_UDMA: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE24
        s_pick_udma
        |=> udma_sel_ff == 7'(7'h01 << $past(set_feat_cnt[2:0])) && mdma_sel_ff == 3'h0)
        else $error("udma mode not selected");

    AST_SEL_BAD: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE24
        s_pick_bad
        |=> $stable(mdma_sel_ff) && $stable(udma_sel_ff))
        else $error("unsupported mode taken");

    AST_ONE_DMA: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE5
        $onehot0(mdma_sel_ff) && $onehot0(udma_sel_ff)
        && !(|mdma_sel_ff && |udma_sel_ff))
        else $error("more than one dma mode selected");

    AST_EN_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE19
        !set_feat_stb
        |=> $stable(en_ff))
        else $error("enable changed without command");

    AST_LOOK_ON: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE19
        set_feat_stb && set_feat_sub == 8'hAA
        |=> en_ff[IDW_EN_LOOK])
        else $error("look-ahead not enabled");

    AST_WR_NOP: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE19
        wr_stb && !set_feat_stb && !set_pw_stb
        |=> $stable(en_ff) && $stable(sec_ff))
        else $error("write changed state");

    AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE25
        rd_stb && addr inside {8'h3E, [8'h45:8'h4F], [8'h59:8'h5A], [8'h5C:8'hBF]}
        |=> rd_data == 16'h0000)
        else $error("unmapped word not zero");

    AST_CTRL: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE21
        s_rd_word(IDW_W_CTRL)
        |=> rd_data == {9'h000, $past(sec_ff), $past(en_ff)})
        else $error("status word wrong");

    // Writes carry no state here; the sink only keeps the bus inputs read
    logic unused_wr;
    assign unused_wr = wr_stb & (^wr_data);
endmodule : idw_words_57_88

// file: test/idw_host_model.sv
// Host controller model that reads identify words and issues device commands
`timescale 1ns/1ns
module idw_host_model (
    input  wire logic        ref_clk,
    output logic [7:0]  addr,
    output logic [15:0] wr_data,
    output logic        wr_stb,
    output logic        rd_stb,
    output logic        set_mult_stb,
    output logic [7:0]  set_mult_cnt,
    output logic        set_feat_stb,
    output logic [7:0]  set_feat_sub,
    output logic [7:0]  set_feat_cnt,
    output logic        set_pw_stb
);
    // One cycle per call; kind 0 drops every strobe, so strobes never overlap
    // Only supported enables sent; unlisted 03H values only to see them ignored
    // No DMA bursts issued, so the 120 ns pacing is never undercut
    task automatic op(input logic [2:0] kind, input logic [7:0] a, input logic [7:0] b, input logic [15:0] d);
        @(posedge ref_clk);
        addr         <= a;
        wr_data      <= d;
        rd_stb       <= (kind == 3'h1);
        wr_stb       <= (kind == 3'h2);
        set_mult_stb <= (kind == 3'h3);
        set_mult_cnt <= b;
        set_feat_stb <= (kind == 3'h4);
        set_feat_sub <= a;
        set_feat_cnt <= b;
        set_pw_stb   <= (kind == 3'h5);
    endtask : op

    initial begin
        {addr, wr_data, wr_stb, rd_stb, set_mult_stb, set_mult_cnt} = '0;
        {set_feat_stb, set_feat_sub, set_feat_cnt, set_pw_stb} = '0;
    end
endmodule : idw_host_model

// file: test/idw_words_57_88_tb_top.sv
// Self-checking bench for the identify words block
`timescale 1ns/1ns
module idw_words_57_88_tb_top;
    logic        ref_clk, rst_n, wr_stb, rd_stb, set_mult_stb, set_feat_stb, set_pw_stb;
    logic [7:0]  addr, set_mult_cnt, set_feat_sub, set_feat_cnt, mc;
    logic [15:0] wr_data, cur_cyl, cur_heads, cur_spt, rd_data;
    logic [31:0] lba_total, seed, cap;
    logic        xlat_pio_valid, sec_enabled, pend;
    logic [5:0]  feat_en;
    logic [15:0] exp_q[$];
    int          n_errors, num_checks, cyc;
    logic [7:0]  fa [13] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h56, 8'h57, 8'h5B};
    logic [15:0] fe [13] = '{16'h0003, 16'h0078, 16'h0078, 16'h0078, 16'h0078, 16'h00FE, 16'h0021,
                             16'h706B, 16'h7408, 16'h4000, 16'h3400, 16'h4000, 16'h0000};
    logic [7:0]  mv [8] = '{8'h22, 8'h21, 8'h45, 8'h23, 8'h40, 8'h20, 8'h46, 8'h47};
    logic [15:0] m63 [8] = '{16'h0407, 16'h0207, 16'h0007, 16'h0007, 16'h0007, 16'h0107, 16'h0007, 16'h0007};
    logic [15:0] m88 [8] = '{16'h007F, 16'h007F, 16'h207F, 16'h207F, 16'h017F, 16'h007F, 16'h407F, 16'h407F};

    idw_host_model idw_host_model_i (.ref_clk, .addr, .wr_data, .wr_stb, .rd_stb, .set_mult_stb, .set_mult_cnt,
                                     .set_feat_stb, .set_feat_sub, .set_feat_cnt, .set_pw_stb);
    idw_words_57_88 idw_words_57_88_i (.ref_clk, .rst_n, .addr, .wr_data, .wr_stb, .rd_stb, .cur_cyl, .cur_heads,
                                       .cur_spt, .lba_total, .set_mult_stb, .set_mult_cnt, .set_feat_stb,
                                       .set_feat_sub, .set_feat_cnt, .set_pw_stb, .rd_data, .xlat_pio_valid,
                                       .feat_en, .sec_enabled);

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (e !== g) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        idw_host_model_i.op(3'h1, a, 8'h00, 16'h0000);
    endtask : rd

    task automatic end_sim;
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Read data stand in the cycle after the strobe is sampled, idle zero otherwise
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend <= 1'b0;
        end else begin
            pend <= rd_stb;
        end
    end

    always @(negedge ref_clk) begin
        if (rst_n && pend && exp_q.size() > 0) cmp("rd_data", exp_q.pop_front(), rd_data);
        else if (rst_n) cmp("rd_idle", 16'h0000, rd_data);
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        {rst_n, cur_cyl, cur_heads, cur_spt, lba_total} = '0;
        seed = 32'h7BBC;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge ref_clk);
        cmp("xlat_pio_valid", 16'h0001, {15'h0, xlat_pio_valid});
        cmp("feat_en", 16'h003F, {10'h0, feat_en});
        for (int i = 0; i < 13; i++) rd(fa[i], fe[i]);
        rd(8'h3B, 16'h0100);
        rd(8'h3F, 16'h0107);
        rd(8'h58, 16'h007F);
        rd(8'h55, 16'h7068);
        rd(8'h3E, 16'h0000);
        rd(8'h45, 16'h0000);
        rd(8'hC0, 16'h003F);
        for (int r = 0; r < 3; r++) begin
            seed = xs(seed);
            mc = seed[31:24];
            cap = {16'h0, seed[15:0]} * {28'h0, seed[19:16]} * {26'h0, seed[25:20]};
            idw_host_model_i.op(3'h0, 8'h00, 8'h00, 16'h0000);
            cur_cyl   <= seed[15:0];
            cur_heads <= {12'h0, seed[19:16]};
            cur_spt   <= {10'h0, seed[25:20]};
            lba_total <= xs(seed);
            idw_host_model_i.op(3'h3, 8'h00, mc, 16'h0000);
            rd(8'h3B, {8'h01, mc});
            rd(8'h39, cap[15:0]);
            rd(8'h3A, cap[31:16]);
            rd(8'h3C, 16'(xs(seed)));
            rd(8'h3D, 16'(xs(seed) >> 16));
        end
        idw_host_model_i.op(3'h2, 8'h52, 8'h00, 16'hFFFF);
        rd(8'h52, 16'h706B);
        idw_host_model_i.op(3'h4, 8'h82, 8'h00, 16'h0000);
        idw_host_model_i.op(3'h4, 8'h55, 8'h00, 16'h0000);
        rd(8'h55, 16'h7008);
        @(negedge ref_clk);
        cmp("feat_en", 16'h0027, {10'h0, feat_en});
        idw_host_model_i.op(3'h4, 8'h02, 8'h00, 16'h0000);
        idw_host_model_i.op(3'h4, 8'hAA, 8'h00, 16'h0000);
        rd(8'h55, 16'h7068);
        for (int i = 0; i < 8; i++) begin
            idw_host_model_i.op(3'h4, 8'h03, mv[i], 16'h0000);
            rd(8'h3F, m63[i]);
            rd(8'h58, m88[i]);
        end
        idw_host_model_i.op(3'h5, 8'h00, 8'h00, 16'h0000);
        rd(8'h55, 16'h706A);
        rd(8'hC0, 16'h007F);
        @(negedge ref_clk);
        cmp("sec_enabled", 16'h0001, {15'h0, sec_enabled});
        idw_host_model_i.op(3'h0, 8'h00, 8'h00, 16'h0000);
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(8'h3B, 16'h0100);
        rd(8'h3F, 16'h0107);
        rd(8'h55, 16'h7068);
        idw_host_model_i.op(3'h0, 8'h00, 8'h00, 16'h0000);
        repeat (4) @(posedge ref_clk);
        end_sim();
    end
endmodule : idw_words_57_88_tb_top
